// ==== design/elss_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module elss_sync
  import elss_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // Sampled stream
  input  wire logic               data_in,
  // Static configuration
  input  wire logic [RATIO_W-1:0] oversample_factor,
  input  wire logic [LIMIT_W-1:0] correction_limit,
  input  wire logic [STEP_W-1:0]  adjust_increment,
  // Recovered timing
  output logic                    data_clk,
  output logic                    early_gate,
  output logic                    late_gate,
  // Recovered data
  output logic                    bit_out,
  output logic                    bit_valid,
  // Loop status
  output logic signed [INT_W-1:0] phase_error,
  output logic                    corr_advance,
  output logic                    corr_retard
);

  // Effective ratio: forced even and at least the minimum
  // Odd settings lose their low bit
  // Settings below the minimum act as the minimum
  // Half ratio splits early and late halves
  logic [RATIO_W-1:0] ratio;
  logic [RATIO_W-1:0] half;

  always_comb
  begin
    ratio = {oversample_factor[RATIO_W-1:1], 1'b0};
    if (ratio < RATIO_MIN)
    begin
      ratio = RATIO_MIN;
    end
    half = {1'b0, ratio[RATIO_W-1:1]};
  end

  // State registers
  logic [RATIO_W-1:0]      phase_q,  phase_d;
  logic signed [INT_W-1:0] early_q,  early_d;
  logic signed [INT_W-1:0] late_q,   late_d;
  logic signed [INT_W-1:0] total_q,  total_d;
  logic signed [ACC_W-1:0] acc_q,    acc_d;
  logic                    clk_q,    clk_d;
  logic                    eg_q,     eg_d;
  logic                    lg_q,     lg_d;
  logic                    bit_q,    bit_d;
  logic                    bv_q,     bv_d;
  logic signed [INT_W-1:0] perr_q,   perr_d;
  logic                    adv_q,    adv_d;
  logic                    ret_q,    ret_d;
  // Retard delay: cycles left before the next symbol starts
  logic [RATIO_W:0]        hold_q,   hold_d;

  // Combinational working values
  logic signed [INT_W-1:0] smp;
  logic signed [INT_W-1:0] e_fin;
  logic signed [INT_W-1:0] l_fin;
  logic signed [INT_W-1:0] t_fin;
  logic signed [INT_W-1:0] e_mag;
  logic signed [INT_W-1:0] l_mag;
  logic signed [INT_W-1:0] theta;
  logic signed [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0]        acc_abs;
  logic                    in_early;
  logic                    sym_end;
  logic                    fire;
  elss_corr_e              corr;
  logic [RATIO_W:0]        wrap_ph;
  logic [RATIO_W:0]        step_red;

  // Loop overview
  // Phase counter runs 0 to ratio-1 per symbol
  // Early half: phase below half ratio
  // Late half: phase from half ratio upward
  // Total sum covers every sample of the symbol
  // Bit decision from sign of total sum
  // Error sign follows the bit decision
  // So a one and a zero symbol give the same error
  // Symbol error added into a wide signed counter
  // Counter wide enough for many symbols of full error
  // Correction only at a symbol end
  // Correction clears the counter
  // Advance: next symbol shorter by the step
  // Retard: next symbol longer by the step
  // Retard parks the phase at zero for step cycles
  // Samples during the park belong to no symbol
  // Park length exceeds one symbol if the step is over twice the ratio
  // Step reduced by one subtraction of the ratio, below the ratio only if under twice it
  // A step equal to the ratio reduces to no shift
  // Large steps make the loop unstable
  // Keep the step small against the ratio
  // Configuration is static while running
  // Changing it mid-symbol can shorten or lengthen that symbol
  // Outputs are registered from next values
  // Gates therefore line up with the phase register
  // Hazard: combinational decode of phase would glitch
  // Registering costs no latency on the gates
  // Result outputs update one cycle after the last sample
  // Valid and direction pulses last one cycle
  // Bit and error hold until the next symbol end

  // Next-state computation for the whole loop
  always_comb
  begin
    phase_d = phase_q;
    hold_d  = hold_q;
    early_d = early_q;
    late_d  = late_q;
    total_d = total_q;
    acc_d   = acc_q;
    bit_d   = bit_q;
    perr_d  = perr_q;
    bv_d    = 1'b0;
    adv_d   = 1'b0;
    ret_d   = 1'b0;
    corr    = ELSS_NONE;
    fire    = 1'b0;

    smp = data_in ? SAMPLE_POS : SAMPLE_NEG;

    in_early = (phase_q < half);
    sym_end  = (phase_q >= ratio - 8'h01);

    // Symbol sums including the current sample
    // early half only
    e_fin = in_early ? early_q + smp : early_q;
    l_fin = in_early ? late_q : late_q + smp;
    t_fin = total_q + smp;

    e_mag = t_fin[INT_W-1] ? -e_fin : e_fin;
    l_mag = t_fin[INT_W-1] ? -l_fin : l_fin;
    theta = e_mag - l_mag;

    acc_sum = acc_q + ACC_W'(theta);
    acc_abs = acc_sum[ACC_W-1] ? ACC_W'(-acc_sum) : ACC_W'(acc_sum);

    // Reduce step by one symbol period when it reaches the ratio
    step_red = {1'b0, adjust_increment};
    if (step_red >= {1'b0, ratio})
    begin
      step_red = step_red - {1'b0, ratio};
    end
    wrap_ph = '0;

    // retard delay
    // Phase and integrators frozen while parked
    if (hold_q != '0)
    begin
      hold_d = hold_q - {{RATIO_W{1'b0}}, 1'b1};
    end
    else if (sym_end)
    begin
      early_d = INT_RST;
      late_d  = INT_RST;
      total_d = INT_RST;
      bit_d   = ~t_fin[INT_W-1];
      bv_d    = 1'b1;
      perr_d  = theta;
      acc_d   = acc_sum;
      fire = (acc_abs > ACC_W'(correction_limit)) && (adjust_increment != '0);
      if (fire)
      begin
        corr = acc_sum[ACC_W-1] ? ELSS_RETARD : ELSS_ADVANCE;
        acc_d = ACC_RST;
      end
      case (corr)
        ELSS_ADVANCE:
        begin
          wrap_ph = step_red;
          adv_d   = 1'b1;
        end
        ELSS_RETARD:
        begin
          // Restart later by the step
          wrap_ph = '0;
          hold_d  = step_red;
          ret_d   = 1'b1;
        end
        default:
        begin
          wrap_ph = '0;
        end
      endcase
      phase_d = wrap_ph[RATIO_W-1:0];
    end
    else
    begin
      early_d = e_fin;
      late_d  = l_fin;
      total_d = t_fin;
      phase_d = phase_q + 8'h01;
    end

    // Registered timing outputs follow the next phase
    // clock and gates
    eg_d  = (phase_d < half);
    lg_d  = ~eg_d;
    clk_d = eg_d;
  end

  // State and output registers
  // async clear
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_q <= PHASE_RST;
      early_q <= INT_RST;
      late_q  <= INT_RST;
      total_q <= INT_RST;
      acc_q   <= ACC_RST;
      clk_q   <= 1'b1;
      eg_q    <= 1'b1;
      lg_q    <= 1'b0;
      bit_q   <= 1'b0;
      bv_q    <= 1'b0;
      perr_q  <= INT_RST;
      adv_q   <= 1'b0;
      ret_q   <= 1'b0;
      hold_q  <= '0;
    end
    else
    begin
      phase_q <= phase_d;
      early_q <= early_d;
      late_q  <= late_d;
      total_q <= total_d;
      acc_q   <= acc_d;
      clk_q   <= clk_d;
      eg_q    <= eg_d;
      lg_q    <= lg_d;
      bit_q   <= bit_d;
      bv_q    <= bv_d;
      perr_q  <= perr_d;
      adv_q   <= adv_d;
      ret_q   <= ret_d;
      hold_q  <= hold_d;
    end
  end

  // Outputs straight from flops
  assign data_clk     = clk_q;
  assign early_gate   = eg_q;
  assign late_gate    = lg_q;
  assign bit_out      = bit_q;
  assign bit_valid    = bv_q;
  assign phase_error  = perr_q;
  assign corr_advance = adv_q;
  assign corr_retard  = ret_q;

endmodule
`default_nettype wire

// ==== design/elss_pkg.sv ====
`default_nettype none
package elss_pkg;
  // Field widths
  localparam int RATIO_W   = 8;
  localparam int LIMIT_W   = 16;
  localparam int STEP_W    = 8;
  localparam int INT_W     = 10;
  localparam int ACC_W     = 18;
  // Documented typical oversampling
  localparam logic [RATIO_W-1:0] RATIO_TYPICAL = 8'h10;
  localparam logic [RATIO_W-1:0] RATIO_MIN     = 8'h04;
  // Reset values
  localparam logic [RATIO_W-1:0] PHASE_RST = 8'h00;
  localparam logic [INT_W-1:0]   INT_RST   = 10'h000;
  localparam logic [ACC_W-1:0]   ACC_RST   = 18'h00000;
  // Per-sample integrator contributions
  localparam logic [INT_W-1:0]   SAMPLE_POS = 10'h001;
  localparam logic [INT_W-1:0]   SAMPLE_NEG = 10'h3ff;
  // Clock rate
  localparam int CLK_PERIOD_NS = 20;
  // Direction of a correction
  typedef enum logic [1:0] {
    ELSS_NONE,
    ELSS_ADVANCE,
    ELSS_RETARD
  } elss_corr_e;
endpackage
`default_nettype wire

// ==== testbench/elss_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module elss_src_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Symbol length and offset
  input  wire logic [7:0] period,
  input  wire logic [7:0] skew,
  // Stream
  output var logic        data_in
);
  logic [7:0] cnt_q;
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      cnt_q   <= skew;
      data_in <= 1'b0;
    end
    else if (cnt_q == period - 8'h01)
    begin
      cnt_q   <= 8'h00;
      data_in <= ~data_in;
    end
    else
      cnt_q <= cnt_q + 8'h01;
endmodule
`default_nettype wire

// ==== testbench/elss_sync_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module elss_sync_assertions
  import elss_pkg::*;
(
  // Clock, reset, setup
  input wire logic                    ref_clk, resetn,
  input wire logic [RATIO_W-1:0]      oversample_factor,
  input wire logic [STEP_W-1:0]       adjust_increment,
  // Outputs
  input wire logic                    data_clk, early_gate, late_gate, bit_out, bit_valid,
  input wire logic signed [INT_W-1:0] phase_error,
  input wire logic                    corr_advance, corr_retard
);
  logic                    corr;
  logic signed [INT_W-1:0] half;
  // Any correction, half symbol
  assign corr = corr_advance | corr_retard;
  assign half = {3'b000, oversample_factor[7:1]};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Symbol end without shift
  sequence s_plain_end;
    bit_valid && !corr;
  endsequence
  a_gate_split: assert property (late_gate != early_gate)
    else $error("gates overlap");
  a_clk_gate: assert property (data_clk == early_gate)
    else $error("clock off gate");
  a_end_pulse: assert property (s_plain_end |=> !bit_valid)
    else $error("valid too long");
  a_sym_start: assert property (s_plain_end |-> early_gate)
    else $error("no early start");
  a_corr_at_end: assert property (corr |-> bit_valid)
    else $error("stray correction");
  a_corr_one_way: assert property (!(corr_advance && corr_retard))
    else $error("both directions");
  a_step_zero: assert property (adjust_increment == 8'h00 |-> !corr)
    else $error("shift while off");
  a_err_hold: assert property (!bit_valid |-> $stable(phase_error) && $stable(bit_out))
    else $error("result moved");
  a_err_bound: assert property (bit_valid |-> phase_error <= half && phase_error >= -half)
    else $error("error too big");
endmodule
bind elss_sync elss_sync_assertions u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .oversample_factor(oversample_factor),
  .adjust_increment(adjust_increment), .data_clk(data_clk), .early_gate(early_gate),
  .late_gate(late_gate), .bit_out(bit_out), .bit_valid(bit_valid),
  .phase_error(phase_error), .corr_advance(corr_advance), .corr_retard(corr_retard));
`default_nettype wire

// ==== testbench/tb_early_late_symbol_synchronizer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_early_late_symbol_synchronizer
  import elss_pkg::*;
;
  logic                    ref_clk = 1'b0;
  logic                    resetn = 1'b0;
  logic [RATIO_W-1:0]      ratio = 8'h08;
  logic [LIMIT_W-1:0]      limit = 16'h0000;
  logic [STEP_W-1:0]       step = 8'h00;
  logic [7:0]              skew = 8'h00;
  logic                    data_in, data_clk, early_gate, late_gate, bit_out, bit_valid, cadv, cret;
  logic signed [INT_W-1:0] perr;
  int                      n_mismatch = 0;
  int                      comparisons = 0;
  // Sample clock
  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  elss_sync dut (.ref_clk(ref_clk), .resetn(resetn), .data_in(data_in),
    .oversample_factor(ratio), .correction_limit(limit), .adjust_increment(step),
    .data_clk(data_clk), .early_gate(early_gate), .late_gate(late_gate), .bit_out(bit_out),
    .bit_valid(bit_valid), .phase_error(perr), .corr_advance(cadv), .corr_retard(cret));
  elss_src_model src (.ref_clk(ref_clk), .resetn(resetn), .period(ratio), .skew(skew),
    .data_in(data_in));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic restart(input logic [7:0] r, s, input logic [15:0] l, input logic [7:0] k);
    @(negedge ref_clk);
    resetn = 1'b0;
    {ratio, step, limit, skew} = {r, s, l, k};
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
  endtask
  // Cycles up to the next symbol end
  task automatic sym(output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (bit_valid !== 1'b1 && n < 600);
  endtask
  task automatic t_reset();
    repeat (3) @(negedge ref_clk);
    cmp({data_clk, early_gate, late_gate, bit_out, bit_valid, cadv, cret}, 7'h60);
    cmp(perr, 10'h000);
  endtask
  // Aligned stream, alternating bits
  task automatic t_aligned(input logic [7:0] r);
    int n;
    restart(r, 8'h00, 16'h0000, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      sym(n);
      cmp(16'(n), 16'(r));
      cmp({bit_out, perr}, {k[0], 10'h000});
    end
  endtask
  // Late stream, threshold reached on second symbol
  task automatic t_retard();
    int n;
    restart(8'h08, 8'h01, 16'h0004, 8'h06);
    sym(n);
    cmp({cadv, cret, perr}, {2'b00, 10'h3fc});
    sym(n);
    cmp({cadv, cret, perr}, {2'b01, 10'h3fc});
    repeat (9) @(negedge ref_clk);
    cmp(bit_valid, 1'b1);
  endtask
  // Early stream, step of two
  task automatic t_advance();
    int n;
    restart(8'h08, 8'h02, 16'h0000, 8'h02);
    sym(n);
    cmp({cadv, cret, perr}, {2'b10, 10'h004});
    repeat (6) @(negedge ref_clk);
    cmp(bit_valid, 1'b1);
  endtask
  // Zero step keeps timing fixed
  task automatic t_disabled();
    int n;
    restart(8'h08, 8'h00, 16'h0000, 8'h06);
    repeat (3)
    begin
      sym(n);
      cmp(16'(n), 16'h0008);
      cmp({cadv, cret, perr}, {2'b00, 10'h3fc});
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_aligned(RATIO_MIN);
    t_aligned(RATIO_TYPICAL);
    t_aligned(8'hfe);
    t_retard();
    t_advance();
    t_disabled();
    conclude();
  end
  // Watchdog
  initial
  begin
    #400000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
